// ---- pmp_pkg.sv ----
// Constants, field layouts and carrier types of the parameter register bank
package pmp_pkg;

    localparam int CLK_HZ         = 40_000_000;
    localparam int MS_PER_S       = 1000;
    localparam int CYCLES_PER_MS  = CLK_HZ / MS_PER_S;
    localparam int CLEAR_UNIT_MS  = 10;
    localparam int CYCLES_PER_CLR = CYCLES_PER_MS * CLEAR_UNIT_MS;
    localparam int WDOG_TIMEOUT_MS = 100;

    localparam logic [5:0] REG_UNLOCK   = 6'h1F;
    localparam logic [5:0] REG_MODE     = 6'h20;
    localparam logic [5:0] REG_ENERGY   = 6'h23;
    localparam logic [5:0] REG_LOWVOLT  = 6'h24;
    localparam logic [5:0] REG_DIVISOR  = 6'h25;
    localparam logic [5:0] REG_CLRTIME  = 6'h26;
    localparam logic [5:0] REG_CYCLE    = 6'h27;

    localparam logic [15:0] CODE_WORD      = 16'h1235;
    localparam logic [15:0] UNLOCK_RESET   = 16'h0000;
    localparam logic [15:0] MODE_RESET     = 16'h0020;
    localparam logic [15:0] MODE_KEEP_MASK = 16'h00FD;
    localparam logic [15:0] ENERGY_RESET   = 16'h0004;
    localparam logic [15:0] ENERGY_MAX     = 16'h0006;
    localparam logic [15:0] LOWVOLT_RESET  = 16'h0064;
    localparam logic [15:0] DIVISOR_RESET  = 16'h0001;
    localparam logic [15:0] CLRTIME_RESET  = 16'h00C8;
    localparam logic [15:0] CYCLE_RESET    = 16'h0032;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    localparam int BIT_AUTO_CLEAR = 7;
    localparam int BIT_SIGN_FLIP  = 6;
    localparam int BIT_SIGNED_PF  = 5;
    localparam int BIT_BYPASS_DC  = 4;
    localparam int BIT_FLEX_IMAGE = 3;
    localparam int BIT_WDOG_OFF   = 2;
    localparam int BIT_SCALING_ON = 0;

    localparam logic [7:0] WRITE_FLAG   = 8'h40;
    localparam int         STATUS_ERR_POS = 6;

    // Control byte as received from the master
    typedef struct packed {
        logic       reg_mode;
        logic       write;
        logic [5:0] reg_num;
    } pmp_ctrl_t;

    // Decoded operating mode bits
    typedef struct packed {
        logic auto_clear_extremes;
        logic generator_sign_flip;
        logic signed_power_factor;
        logic bypass_offset_filter;
        logic flexible_image_select;
        logic watchdog_disable;
        logic transformer_scaling_on;
    } pmp_mode_t;

endpackage

// ---- pmp_unit_timer.sv ----
// Programmable interval timer counting whole units of a fixed cycle length
`timescale 1ns/1ps
module pmp_unit_timer #(
    parameter int UNIT_CYCLES = 40000,
    parameter int UNITS_W     = 16
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               run_i,
    input  wire logic               restart_i,
    input  wire logic [UNITS_W-1:0] units_i,
    output logic                    expire_o
);
    localparam int PW = $clog2(UNIT_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYCLES - 1);

    logic [PW-1:0]      pre;
    logic [UNITS_W-1:0] cnt;
    logic [UNITS_W-1:0] units_last;
    logic               tick;
    logic               hold;

    // Zero units behaves as one so the timer never stalls
    assign units_last = (units_i == '0) ? '0 : units_i - 1'b1;
    assign tick       = (pre == PRE_LAST);
    assign hold       = restart_i | ~run_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre <= '0;
        end else if (hold || tick) begin
            pre <= '0;
        end else begin
            pre <= pre + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (hold) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= (cnt >= units_last) ? '0 : cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= ~hold & tick & (cnt >= units_last);
        end
    end

endmodule // pmp_unit_timer

// ---- pmp_param_bank.sv ----
// Parameter register bank with register-communication access over the process image
// Behaviour
// - Auto-clear bit set periodically clears stored min and max values.
// - Sign-flip bit inverts accumulated energy sign for generator operation.
// - Power factor always positive unless signed bit set; then capacitive negative.
// - Bypass bit routes samples around the offset filter.
// - Flexible-image bit selects process image layout; default per variant.
// - Watchdog trips after 100 ms without process data unless disabled.
// - Scaling bit set divides measured current by the divisor register.
// - Energy unit register selects unit by code 0..6, default 4.
// - Voltage below low limit sets status error bit and error indicator.
// - Auto-clear interval counts 10 ms units, default 200.
// - Measuring cycle follows cycle register in 1 ms steps, default 50.
// - Control bit 7 selects register communication mode.
// - Control bit 6 set requests write, clear requests read.
// - Control bits 5..0 carry the addressed register number.
// - Read acknowledge copies control byte unchanged into status byte.
// - Read returns register content in input word, high byte first.
// - Output word ignored on read; carries value on write.
// - User registers reject writes until code word written to unlock register.
// - Any other value in unlock register restores write protection.
// - Changed register contents need only take effect after power cycle.
// - Write acknowledge returns control byte with bit 6 toggled.
// - Restart clears unlock register, so protection is active again.
`timescale 1ns/1ps
module pmp_param_bank #(
    parameter logic FLEX_DEFAULT   = 1'b0,
    parameter int   MS_CYCLES      = pmp_pkg::CYCLES_PER_MS,
    parameter int   CLR_UNIT_CYCLES = pmp_pkg::CYCLES_PER_CLR
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              pd_valid_i,
    input  wire logic [7:0]        ctrl_byte_i,
    input  wire logic [15:0]       data_out_word_i,
    input  wire logic [15:0]       mains_voltage_i,
    input  wire logic [15:0]       current_raw_i,
    input  wire logic signed [31:0] energy_raw_i,
    input  wire logic [14:0]       pf_magnitude_i,
    input  wire logic              pf_capacitive_i,
    input  wire logic [15:0]       sample_raw_i,
    input  wire logic [15:0]       sample_filtered_i,
    output logic [7:0]             status_byte_o,
    output logic [15:0]            data_in_word_o,
    output pmp_pkg::pmp_mode_t     mode_o,
    output logic [2:0]             energy_unit_o,
    output logic [15:0]            current_o,
    output logic signed [31:0]     energy_o,
    output logic signed [15:0]     power_factor_o,
    output logic [15:0]            sample_o,
    output logic                   clear_extremes_o,
    output logic                   measure_start_o,
    output logic                   watchdog_trip_o,
    output logic                   error_led_o
);
    localparam logic [15:0] WDOG_UNITS = 16'(pmp_pkg::WDOG_TIMEOUT_MS);
    localparam logic [15:0] MODE_INIT  =
        pmp_pkg::MODE_RESET | (16'(FLEX_DEFAULT) << pmp_pkg::BIT_FLEX_IMAGE);

    pmp_pkg::pmp_ctrl_t ctrl;
    logic [15:0]        unlock_word_register;
    logic [15:0]        operating_mode_bits;
    logic [15:0]        energy_unit_select;
    logic [15:0]        low_voltage_limit;
    logic [15:0]        transformer_ratio_divisor;
    logic [15:0]        extremes_clear_interval;
    logic [15:0]        sample_cycle_period;
    logic [15:0]        rd_val;
    logic [15:0]        divisor_safe;
    logic               unlocked;
    logic               reg_access;
    logic               reg_write;
    logic               uv_error;
    logic               clr_expire;
    logic               wdog_expire;

    assign ctrl = pmp_pkg::pmp_ctrl_t'(ctrl_byte_i);
    assign reg_access = pd_valid_i & ctrl.reg_mode;
    assign reg_write  = reg_access & ctrl.write;
    assign unlocked   = (unlock_word_register == pmp_pkg::CODE_WORD);

    always_comb begin
        case (ctrl.reg_num)
            pmp_pkg::REG_UNLOCK:  rd_val = unlock_word_register;
            pmp_pkg::REG_MODE:    rd_val = operating_mode_bits;
            pmp_pkg::REG_ENERGY:  rd_val = energy_unit_select;
            pmp_pkg::REG_LOWVOLT: rd_val = low_voltage_limit;
            pmp_pkg::REG_DIVISOR: rd_val = transformer_ratio_divisor;
            pmp_pkg::REG_CLRTIME: rd_val = extremes_clear_interval;
            pmp_pkg::REG_CYCLE:   rd_val = sample_cycle_period;
            default:              rd_val = pmp_pkg::WORD_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            unlock_word_register <= pmp_pkg::UNLOCK_RESET;
        end else if (reg_write && ctrl.reg_num == pmp_pkg::REG_UNLOCK) begin
            // Any value is stored; only the code word unlocks
            unlock_word_register <= data_out_word_i;
        end
    end

    // Protected user registers
    // Settings act at once; a later restart is not needed here
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            operating_mode_bits       <= MODE_INIT;
            energy_unit_select        <= pmp_pkg::ENERGY_RESET;
            low_voltage_limit         <= pmp_pkg::LOWVOLT_RESET;
            transformer_ratio_divisor <= pmp_pkg::DIVISOR_RESET;
            extremes_clear_interval   <= pmp_pkg::CLRTIME_RESET;
            sample_cycle_period       <= pmp_pkg::CYCLE_RESET;
        end else if (reg_write && unlocked) begin
            case (ctrl.reg_num)
                pmp_pkg::REG_MODE: begin
                    operating_mode_bits <= data_out_word_i & pmp_pkg::MODE_KEEP_MASK;
                end
                pmp_pkg::REG_ENERGY: begin
                    if (data_out_word_i <= pmp_pkg::ENERGY_MAX) begin
                        energy_unit_select <= data_out_word_i;
                    end
                end
                pmp_pkg::REG_LOWVOLT: begin
                    low_voltage_limit <= data_out_word_i;
                end
                pmp_pkg::REG_DIVISOR: begin
                    transformer_ratio_divisor <= data_out_word_i;
                end
                pmp_pkg::REG_CLRTIME: begin
                    extremes_clear_interval <= data_out_word_i;
                end
                pmp_pkg::REG_CYCLE: begin
                    sample_cycle_period <= data_out_word_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Acknowledge path; answers only when process data arrives
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_byte_o  <= 8'h00;
            data_in_word_o <= pmp_pkg::WORD_ZERO;
        end else if (reg_write) begin
            status_byte_o  <= ctrl_byte_i ^ pmp_pkg::WRITE_FLAG;
            data_in_word_o <= pmp_pkg::WORD_ZERO;
        end else if (reg_access) begin
            status_byte_o  <= ctrl_byte_i;
            data_in_word_o <= rd_val;
        end else if (pd_valid_i) begin
            status_byte_o  <= 8'(uv_error) << pmp_pkg::STATUS_ERR_POS;
            data_in_word_o <= pmp_pkg::WORD_ZERO;
        end
    end

    // Mode decode
    assign mode_o.auto_clear_extremes    = operating_mode_bits[pmp_pkg::BIT_AUTO_CLEAR];
    assign mode_o.generator_sign_flip    = operating_mode_bits[pmp_pkg::BIT_SIGN_FLIP];
    assign mode_o.signed_power_factor    = operating_mode_bits[pmp_pkg::BIT_SIGNED_PF];
    assign mode_o.bypass_offset_filter   = operating_mode_bits[pmp_pkg::BIT_BYPASS_DC];
    assign mode_o.flexible_image_select  = operating_mode_bits[pmp_pkg::BIT_FLEX_IMAGE];
    assign mode_o.watchdog_disable       = operating_mode_bits[pmp_pkg::BIT_WDOG_OFF];
    assign mode_o.transformer_scaling_on = operating_mode_bits[pmp_pkg::BIT_SCALING_ON];
    assign energy_unit_o = energy_unit_select[2:0];

    // Divisor of zero would be undefined; treated as one
    assign divisor_safe = (transformer_ratio_divisor == pmp_pkg::WORD_ZERO) ?
                          pmp_pkg::DIVISOR_RESET : transformer_ratio_divisor;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            current_o      <= pmp_pkg::WORD_ZERO;
            energy_o       <= '0;
            power_factor_o <= '0;
            sample_o       <= pmp_pkg::WORD_ZERO;
            uv_error       <= 1'b0;
        end else begin
            current_o      <= mode_o.transformer_scaling_on ?
                              current_raw_i / divisor_safe : current_raw_i;
            energy_o       <= mode_o.generator_sign_flip ? -energy_raw_i : energy_raw_i;
            power_factor_o <= (mode_o.signed_power_factor && pf_capacitive_i) ?
                              -$signed({1'b0, pf_magnitude_i}) : $signed({1'b0, pf_magnitude_i});
            sample_o       <= mode_o.bypass_offset_filter ? sample_raw_i : sample_filtered_i;
            uv_error       <= (mains_voltage_i < low_voltage_limit);
        end
    end

    assign error_led_o = uv_error;

    pmp_unit_timer #(
        .UNIT_CYCLES (CLR_UNIT_CYCLES),
        .UNITS_W     (16)
    ) u_clear_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (mode_o.auto_clear_extremes),
        .restart_i (1'b0),
        .units_i   (extremes_clear_interval),
        .expire_o  (clr_expire)
    );
    assign clear_extremes_o = clr_expire & mode_o.auto_clear_extremes;

    pmp_unit_timer #(
        .UNIT_CYCLES (MS_CYCLES),
        .UNITS_W     (16)
    ) u_cycle_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (1'b1),
        .restart_i (1'b0),
        .units_i   (sample_cycle_period),
        .expire_o  (measure_start_o)
    );

    // Watchdog timer, restarted by process data
    pmp_unit_timer #(
        .UNIT_CYCLES (MS_CYCLES),
        .UNITS_W     (16)
    ) u_wdog_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (~mode_o.watchdog_disable),
        .restart_i (pd_valid_i),
        .units_i   (WDOG_UNITS),
        .expire_o  (wdog_expire)
    );

    // Trip wins over a clearing data arrival
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            watchdog_trip_o <= 1'b0;
        end else if (mode_o.watchdog_disable) begin
            watchdog_trip_o <= 1'b0;
        end else if (wdog_expire) begin
            watchdog_trip_o <= 1'b1;
        end else if (pd_valid_i) begin
            watchdog_trip_o <= 1'b0;
        end
    end

    sequence s_read_req;
        reg_access && !ctrl.write;
    endsequence

    sequence s_unlock_wr;
        reg_write && ctrl.reg_num == pmp_pkg::REG_UNLOCK;
    endsequence

    property p_read_echo;
        @(posedge clk_i) disable iff (rst_i)
        s_read_req |=> status_byte_o == $past(ctrl_byte_i) && data_in_word_o == $past(rd_val);
    endproperty
    a_read_echo: assert property (p_read_echo) else $error("read ack wrong");

    property p_write_ack;
        @(posedge clk_i) disable iff (rst_i)
        reg_write |=> status_byte_o == ($past(ctrl_byte_i) ^ pmp_pkg::WRITE_FLAG);
    endproperty
    a_write_ack: assert property (p_write_ack) else $error("write ack wrong");

    property p_locked_reject;
        @(posedge clk_i) disable iff (rst_i)
        reg_write && !unlocked && ctrl.reg_num == pmp_pkg::REG_MODE
        |=> $stable(operating_mode_bits);
    endproperty
    a_locked_reject: assert property (p_locked_reject) else $error("locked write took");

    property p_unlock;
        @(posedge clk_i) disable iff (rst_i)
        s_unlock_wr ##0 data_out_word_i == pmp_pkg::CODE_WORD |=> unlocked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("code word failed to unlock");

    property p_relock;
        @(posedge clk_i) disable iff (rst_i)
        s_unlock_wr ##0 data_out_word_i != pmp_pkg::CODE_WORD |=> !unlocked;
    endproperty
    a_relock: assert property (p_relock) else $error("protection not restored");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        (operating_mode_bits & ~pmp_pkg::MODE_KEEP_MASK) == pmp_pkg::WORD_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_undervolt;
        @(posedge clk_i) disable iff (rst_i)
        mains_voltage_i < low_voltage_limit ##1 pd_valid_i && !ctrl.reg_mode
        |=> status_byte_o[pmp_pkg::STATUS_ERR_POS] && error_led_o;
    endproperty
    a_undervolt: assert property (p_undervolt) else $error("undervoltage not flagged");

    property p_scale_off;
        @(posedge clk_i) disable iff (rst_i)
        !mode_o.transformer_scaling_on |=> current_o == $past(current_raw_i);
    endproperty
    a_scale_off: assert property (p_scale_off) else $error("unscaled current wrong");

    property p_pf_positive;
        @(posedge clk_i) disable iff (rst_i)
        !mode_o.signed_power_factor |=> power_factor_o >= 0;
    endproperty
    a_pf_positive: assert property (p_pf_positive) else $error("power factor negative");

    property p_wdog_off;
        @(posedge clk_i) disable iff (rst_i)
        mode_o.watchdog_disable |=> !watchdog_trip_o;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("watchdog tripped while off");

    property p_clear_gated;
        @(posedge clk_i) disable iff (rst_i)
        clear_extremes_o |-> mode_o.auto_clear_extremes;
    endproperty
    a_clear_gated: assert property (p_clear_gated) else $error("clear while disabled");

endmodule // pmp_param_bank

// ---- pmp_master_model.sv ----
// Bus master model issuing one register access per request
`timescale 1ns/1ps
module pmp_master_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [7:0]  ctrl_i,
    input  wire logic [15:0] data_i,
    output logic             pd_valid_o,
    output logic [7:0]       ctrl_byte_o,
    output logic [15:0]      data_out_word_o,
    output logic             ack_o
);
    logic [1:0] phase;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase           <= 2'h0;
            pd_valid_o      <= 1'b0;
            ack_o           <= 1'b0;
            ctrl_byte_o     <= 8'h00;
            data_out_word_o <= 16'h0000;
        end else begin
            pd_valid_o <= go_i && (phase == 2'h0);
            ack_o      <= (phase == 2'h2);
            if (go_i && (phase == 2'h0)) begin
                phase           <= 2'h1;
                ctrl_byte_o     <= ctrl_i;
                data_out_word_o <= data_i;
            end else begin
                // Answer stands one cycle after the taking edge
                phase <= (phase == 2'h1) ? 2'h2 : 2'h0;
            end
        end
    end
endmodule // pmp_master_model

// ---- power_meter_param_registers_tb.sv ----
// Self-checking bench of the parameter register bank
`timescale 1ns/1ps
module power_meter_param_registers_tb;
    logic               clk, rst, go, pd, ack, pc, uv;
    logic [7:0]         c, cb, st;
    logic [15:0]        d, dw, di, mv, cr, sr, sf, co, so, v;
    logic signed [31:0] er, eo;
    logic signed [15:0] pfo;
    logic [14:0]        pm;
    logic [2:0]         eu;
    logic               clr, ms, wd, led;
    pmp_pkg::pmp_mode_t md;
    logic [23:0]        eq[$];
    int                 bad_count, cmp_count, cyc, lc, lm, gc, gm;

    pmp_master_model mst_u (.clk_i(clk), .rst_i(rst), .go_i(go), .ctrl_i(c), .data_i(d),
        .pd_valid_o(pd), .ctrl_byte_o(cb), .data_out_word_o(dw), .ack_o(ack));
    // Short timers keep the run brief
    pmp_param_bank #(.MS_CYCLES(4), .CLR_UNIT_CYCLES(8)) dut_u (.clk_i(clk), .rst_i(rst),
        .pd_valid_i(pd), .ctrl_byte_i(cb), .data_out_word_i(dw), .mains_voltage_i(mv),
        .current_raw_i(cr), .energy_raw_i(er), .pf_magnitude_i(pm), .pf_capacitive_i(pc),
        .sample_raw_i(sr), .sample_filtered_i(sf), .status_byte_o(st), .data_in_word_o(di),
        .mode_o(md), .energy_unit_o(eu), .current_o(co), .energy_o(eo),
        .power_factor_o(pfo), .sample_o(so), .clear_extremes_o(clr),
        .measure_start_o(ms), .watchdog_trip_o(wd), .error_led_o(led));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Expected answer noted before the request goes out
    task automatic acc(input logic [7:0] k, input logic [15:0] x, input logic [15:0] e);
        logic [7:0] s;
        s = k[7] ? (k[6] ? k ^ 8'h40 : k) : {1'b0, uv, 6'h00};
        @(posedge clk);
        go <= 1'b1;
        c  <= k;
        d  <= x;
        eq.push_back({s, e});
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] n, input logic [15:0] e);
        acc({2'b10, n}, 16'($urandom), e);
    endtask

    task automatic wr(input logic [5:0] n, input logic [15:0] x);
        acc({2'b11, n}, x, 16'h0000);
    endtask

    always @(posedge clk) begin : mon
        cyc++;
        if (clr === 1'b1) begin
            gc = cyc - lc;
            lc = cyc;
        end
        if (ms === 1'b1) begin
            gm = cyc - lm;
            lm = cyc;
        end
        if (ack === 1'b1) begin
            if (eq.size() == 0) chk(32'h0, 32'h1);
            else chk({st, di}, eq.pop_front());
        end
    end

    initial begin
        #2_000_000;
        bad_count++;
        summarize();
    end

    initial begin
        rst = 1'b1; go = 1'b0; c = 8'h00; d = 16'h0000; uv = 1'b0;
        mv = 16'h0200; cr = 16'h0000; er = 0; pm = 15'h0000; pc = 1'b0;
        sr = 16'h0000; sf = 16'h0000;
        void'($urandom(32'h25F651E5));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(6'h1F, 16'h0000);
        rd(6'h20, 16'h0020);
        rd(6'h23, 16'h0004);
        rd(6'h24, 16'h0064);
        rd(6'h25, 16'h0001);
        rd(6'h26, 16'h00C8);
        rd(6'h27, 16'h0032);
        rd(6'h21, 16'h0000);
        chk(eu, 3'h4);
        chk(led, 1'b0);
        wr(6'h20, 16'h00FF);
        rd(6'h20, 16'h0020);
        wr(6'h1F, pmp_pkg::CODE_WORD);
        rd(6'h1F, pmp_pkg::CODE_WORD);
        v = 16'($urandom);
        wr(6'h20, v);
        rd(6'h20, v & pmp_pkg::MODE_KEEP_MASK);
        chk(md, {v[7], v[6], v[5], v[4], v[3], v[2], v[0]});
        wr(6'h23, 16'h0007);
        rd(6'h23, 16'h0004);
        wr(6'h23, 16'h0003);
        rd(6'h23, 16'h0003);
        chk(eu, 3'h3);
        wr(6'h25, 16'h0004);
        wr(6'h20, 16'h00F1);
        cr <= 16'($urandom);
        er <= $urandom;
        pm <= 15'($urandom);
        pc <= 1'b1;
        sr <= 16'($urandom);
        sf <= 16'($urandom);
        repeat (3) @(posedge clk);
        chk(co, cr / 16'h0004);
        chk(eo, 32'(-er));
        chk(pfo[15:0], 16'(16'h0000 - {1'b0, pm}));
        chk(so, sr);
        wr(6'h20, 16'h0000);
        repeat (3) @(posedge clk);
        chk(co, cr);
        chk(eo, er);
        chk(pfo[15:0], {1'b0, pm});
        chk(so, sf);
        repeat (390) @(posedge clk);
        chk(wd, 1'b0);
        repeat (30) @(posedge clk);
        chk(wd, 1'b1);
        wr(6'h26, 16'h0002);
        wr(6'h27, 16'h0003);
        wr(6'h20, 16'h0084);
        repeat (420) @(posedge clk);
        chk(wd, 1'b0);
        chk(gc, 16);
        chk(gm, 12);
        wr(6'h1F, 16'h0000);
        wr(6'h24, 16'h0032);
        rd(6'h24, 16'h0064);
        mv <= 16'h0032;
        uv = 1'b1;
        repeat (3) @(posedge clk);
        chk(led, 1'b1);
        acc(8'h00, 16'h0000, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(6'h1F, 16'h0000);
        rd(6'h20, 16'h0020);
        summarize();
    end
endmodule // power_meter_param_registers_tb
